// *** design/sdram_burst_pkg.sv ***
// Shared widths, mode codes, timing counts and types for the SDRAM burst pair.
// Assumes one clock of 25 MHz shared by the memory end and the controller end.
package sdram_burst_pkg;
	// Pin widths
	localparam int BANK_W = 2;
	localparam int BANKS = 4;
	localparam int COL_W = 10;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;
	localparam int MASK_W = DATA_W / BYTE_W;
	// Address bit that asks for auto precharge
	localparam int PSB_POS = 10;

	// Burst length field codes
	localparam logic [2:0] BL_CODE_1 = 3'h0;
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] BL_CODE_FULL = 3'h7;
	// Burst lengths in words
	localparam int LEN_2 = 2;
	localparam int LEN_4 = 4;
	localparam int LEN_8 = 8;
	localparam int FULL_PAGE_LEN = 1024;
	// CAS latency field codes
	localparam logic [2:0] CL_CODE_2 = 3'h2;
	localparam logic [2:0] CL_CODE_3 = 3'h3;
	localparam int CL_2 = 2;
	localparam int CL_3 = 3;

	// Clock and command spacing
	localparam int CLK_PERIOD_NS = 40;
	localparam int PRECHARGE_TIME_NS = 20;
	localparam int WRITE_RECOVERY_TIME_NS = 15;
	localparam int WAIT_W = 12;

	// Least time in ns to whole cycles, never below one
	function automatic int ceil_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int PRECHARGE_CYC = ceil_cyc(PRECHARGE_TIME_NS);
	localparam int WRITE_RECOVERY_CYC = ceil_cyc(WRITE_RECOVERY_TIME_NS);

	// Burst length less one, as a column mask; reserved codes act as one
	function automatic logic [COL_W-1:0] bl_mask(input logic [2:0] code);
		case (code)
			BL_CODE_2: return COL_W'(LEN_2 - 1);
			BL_CODE_4: return COL_W'(LEN_4 - 1);
			BL_CODE_8: return COL_W'(LEN_8 - 1);
			BL_CODE_FULL: return COL_W'(FULL_PAGE_LEN - 1);
			default: return '0;
		endcase
	endfunction

	// Burst engine states
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} burst_e;

	// One queued controller request
	typedef struct packed {
		logic write;
		logic autopre;
		logic [BANK_W-1:0] bank;
		logic [COL_W-1:0] col;
		logic [DATA_W-1:0] data;
		logic [MASK_W-1:0] mask;
	} req_s;
endpackage

// *** design/sdram_link_if.sv ***
// Pin bundle between the SDRAM controller end and the memory end.
// Assumes both ends share one clock; the data wire is resolved per byte lane here.
interface sdram_link_if;
	// Command pins, driven by the controller
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [sdram_burst_pkg::BANK_W-1:0] ba;
	logic [sdram_burst_pkg::ADDR_W-1:0] addr;
	logic [sdram_burst_pkg::MASK_W-1:0] dqm;
	// Data pins, one driver per end plus the resolved level
	logic [sdram_burst_pkg::DATA_W-1:0] dq_c_out;
	logic [sdram_burst_pkg::MASK_W-1:0] dq_c_oe;
	logic [sdram_burst_pkg::DATA_W-1:0] dq_m_out;
	logic [sdram_burst_pkg::MASK_W-1:0] dq_m_oe;
	logic [sdram_burst_pkg::DATA_W-1:0] dq;

	// Lane level; an undriven lane reads as zero
	always_comb begin
		for (int b = 0; b < sdram_burst_pkg::MASK_W; b++) begin
			if (dq_m_oe[b])
				dq[b*8 +: 8] = dq_m_out[b*8 +: 8];
			else if (dq_c_oe[b])
				dq[b*8 +: 8] = dq_c_out[b*8 +: 8];
			else
				dq[b*8 +: 8] = 8'h00;
		end
	end

	modport ctrl (
		output cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_c_out, dq_c_oe,
		input dq
	);
	modport mem (
		input cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
		output dq_m_out, dq_m_oe
	);
endinterface

// *** design/sdram_burst_mem.sv ***
// Memory end of the SDRAM link: read and write burst engine with its array.
// Assumes mode fields and bank-active state come from neighbouring logic.
module sdram_burst_mem #(
	parameter int COLS = sdram_burst_pkg::FULL_PAGE_LEN
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Pins from the controller
	sdram_link_if.mem bus,
	// Mode register fields
	input wire logic [2:0] i_burst_len_code,
	input wire logic i_burst_type,
	input wire logic [2:0] i_cas_lat_code,
	// Bank state from activate logic
	input wire logic [sdram_burst_pkg::BANKS-1:0] i_bank_active,
	// Burst status
	output logic o_busy,
	// Auto precharge request
	output logic o_ap_req,
	output logic [sdram_burst_pkg::BANK_W-1:0] o_ap_bank
);
	localparam int COL_W = sdram_burst_pkg::COL_W;
	localparam int BANK_W = sdram_burst_pkg::BANK_W;
	localparam int DATA_W = sdram_burst_pkg::DATA_W;
	localparam int MASK_W = sdram_burst_pkg::MASK_W;
	localparam int BYTE_W = sdram_burst_pkg::BYTE_W;
	localparam int BANKS = sdram_burst_pkg::BANKS;

	// Column of word idx in a burst from start
	function automatic logic [COL_W-1:0] burst_col(
		input logic [COL_W-1:0] start,
		input logic [COL_W-1:0] idx,
		input logic [2:0] code,
		input logic ilv
	);
		logic [COL_W-1:0] m;
		logic [COL_W-1:0] off;
		m = sdram_burst_pkg::bl_mask(code);
		// Interleave only for lengths four and eight
		if (ilv && (code == sdram_burst_pkg::BL_CODE_4 || code == sdram_burst_pkg::BL_CODE_8))
			off = start ^ idx;
		else
			off = start + idx;
		return (start & ~m) | (off & m);
	endfunction

	// Storage, one word per bank and column
	logic [DATA_W-1:0] mem [BANKS*COLS];

	// Burst engine state
	sdram_burst_pkg::burst_e state_reg;
	sdram_burst_pkg::burst_e state_next;
	logic [BANK_W-1:0] bank_reg; // bank of the running burst
	logic [COL_W-1:0] start_reg; // starting column
	logic [COL_W-1:0] cnt_reg; // index of next word
	logic ap_reg; // auto precharge pending at burst end

	// Read pipeline, one stage per extra latency clock
	logic pipe0_v_reg;
	logic [DATA_W-1:0] pipe0_d_reg;
	logic pipe1_v_reg;
	logic [DATA_W-1:0] pipe1_d_reg;
	logic [MASK_W-1:0] dqm_d1_reg; // mask from one edge back
	logic [DATA_W-1:0] dq_out_reg;
	logic [MASK_W-1:0] dq_oe_reg;

	// Command decode
	wire sel = ~bus.cs_n;
	wire col_cmd = sel & bus.ras_n & ~bus.cas_n;
	wire bank_ok = i_bank_active[bus.ba];
	// Inactive bank: the command is dropped
	wire cmd_rd = col_cmd & bus.we_n & bank_ok;
	wire cmd_wr = col_cmd & ~bus.we_n & bank_ok;
	wire cmd_pre = sel & ~bus.ras_n & bus.cas_n & ~bus.we_n;
	wire pre_all = bus.addr[sdram_burst_pkg::PSB_POS];
	wire new_burst = cmd_rd | cmd_wr;
	// Precharge hits the burst if same bank or all banks
	wire pre_hit = cmd_pre & (pre_all | bus.ba == bank_reg);
	// Any interrupting command ends the running burst
	wire stop = new_burst | pre_hit;

	// Mode decode
	wire full = i_burst_len_code == sdram_burst_pkg::BL_CODE_FULL;
	wire [COL_W-1:0] len_m = sdram_burst_pkg::bl_mask(i_burst_len_code);
	wire cl3 = i_cas_lat_code == sdram_burst_pkg::CL_CODE_3;

	// Word issued at this edge
	wire cont_rd = state_reg == sdram_burst_pkg::ST_READ & ~stop;
	wire cont_wr = state_reg == sdram_burst_pkg::ST_WRITE & ~stop;
	wire issue_rd = cmd_rd | cont_rd;
	// A read registered here blocks further write words
	wire issue_wr = cmd_wr | cont_wr;
	wire [COL_W-1:0] cur_start = new_burst ? bus.addr[COL_W-1:0] : start_reg;
	wire [COL_W-1:0] cur_idx = new_burst ? '0 : cnt_reg;
	wire [BANK_W-1:0] cur_bank = new_burst ? bus.ba : bank_reg;
	wire [COL_W-1:0] cur_col = burst_col(cur_start, cur_idx, i_burst_len_code, i_burst_type);
	wire [BANK_W+COL_W-1:0] cur_addr = {cur_bank, cur_col};
	// Last word unless full page, which runs until cut
	wire is_last = ~full & (cur_idx == len_m);
	wire issuing = issue_rd | issue_wr;
	// Auto precharge request of the current burst
	wire cur_ap = new_burst ? (pre_all & ~full) : ap_reg;

	// Pipeline tap for the programmed latency
	wire sel_v = cl3 ? pipe1_v_reg : pipe0_v_reg;
	wire [DATA_W-1:0] sel_d = cl3 ? pipe1_d_reg : pipe0_d_reg;

	// Next burst state
	always_comb begin
		state_next = state_reg;
		if (new_burst & is_last)
			state_next = sdram_burst_pkg::ST_IDLE;
		else if (cmd_rd)
			state_next = sdram_burst_pkg::ST_READ;
		else if (cmd_wr)
			state_next = sdram_burst_pkg::ST_WRITE;
		else if (pre_hit | (issuing & is_last))
			state_next = sdram_burst_pkg::ST_IDLE;
	end

	// Burst engine registers
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= sdram_burst_pkg::ST_IDLE;
			bank_reg <= '0;
			start_reg <= '0;
			cnt_reg <= '0;
			ap_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			// Latch a fresh burst
			if (new_burst) begin
				bank_reg <= bus.ba;
				start_reg <= bus.addr[COL_W-1:0];
				ap_reg <= pre_all & ~full;
			end
			// Counter wraps at page end
			cnt_reg <= cur_idx + COL_W'(1);
		end
	end

	// Auto precharge pulse after the natural last word
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ap_req <= 1'b0;
			o_ap_bank <= '0;
			o_busy <= 1'b0;
		end else begin
			o_ap_req <= issuing & is_last & cur_ap;
			o_ap_bank <= cur_bank;
			o_busy <= state_next != sdram_burst_pkg::ST_IDLE;
		end
	end

	// Write capture, byte lanes masked by this edge's mask
	always_ff @(posedge i_sys_clk) begin
		if (issue_wr) begin
			for (int b = 0; b < MASK_W; b++) begin
				if (!bus.dqm[b])
					mem[cur_addr][b*BYTE_W +: BYTE_W] <= bus.dq[b*BYTE_W +: BYTE_W];
			end
		end
	end

	// Read pipeline; words in flight survive an interrupt
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pipe0_v_reg <= 1'b0;
			pipe0_d_reg <= '0;
			pipe1_v_reg <= 1'b0;
			pipe1_d_reg <= '0;
		end else begin
			pipe0_v_reg <= issue_rd;
			pipe0_d_reg <= mem[cur_addr];
			pipe1_v_reg <= pipe0_v_reg;
			pipe1_d_reg <= pipe0_d_reg;
		end
	end

	// Output stage; mask delay is two edges in total
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			dqm_d1_reg <= '1;
			dq_out_reg <= '0;
			dq_oe_reg <= '0;
		end else begin
			dqm_d1_reg <= bus.dqm;
			dq_out_reg <= sel_d;
			// No valid word means pins released
			dq_oe_reg <= {MASK_W{sel_v}} & ~dqm_d1_reg;
		end
	end

	// Pins are driven only from registers
	assign bus.dq_m_out = dq_out_reg;
	assign bus.dq_m_oe = dq_oe_reg;
endmodule

// *** design/sdram_burst_ctrl.sv ***
// Controller end of the SDRAM link: issues single-word reads and writes.
// Assumes the activate logic reports which banks have met row_to_column_delay.
module sdram_burst_ctrl #(
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Pins to the memory
	sdram_link_if.ctrl bus,
	// Mode fields, same as given to the memory
	input wire logic [2:0] i_burst_len_code,
	input wire logic [2:0] i_cas_lat_code,
	// Banks ready for column commands
	input wire logic [sdram_burst_pkg::BANKS-1:0] i_bank_ready,
	// Request stream
	input wire logic i_req_valid,
	input wire sdram_burst_pkg::req_s i_req,
	output logic o_req_ready,
	// Read answers
	output logic o_rd_valid,
	output logic [sdram_burst_pkg::DATA_W-1:0] o_rd_data
);
	localparam int COL_W = sdram_burst_pkg::COL_W;
	localparam int ADDR_W = sdram_burst_pkg::ADDR_W;
	localparam int WAIT_W = sdram_burst_pkg::WAIT_W;
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	// Two-entry request buffer
	sdram_burst_pkg::req_s buf_q [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [WAIT_W-1:0] wait_reg; // auto precharge spacing
	logic [WAIT_W-1:0] gap_reg; // read to write spacing
	logic [3:0] rd_sr_reg; // read issue history

	wire sdram_burst_pkg::req_s head = buf_q[rd_ptr_reg];
	wire cl3 = i_cas_lat_code == sdram_burst_pkg::CL_CODE_3;
	wire full = i_burst_len_code == sdram_burst_pkg::BL_CODE_FULL;
	wire [WAIT_W-1:0] len_m = WAIT_W'(sdram_burst_pkg::bl_mask(i_burst_len_code));
	// Issue only when the bank is ready and spacing is met
	wire issue = cnt_reg != '0 & wait_reg == '0 & i_bank_ready[head.bank]
		& (~head.write | gap_reg == '0);
	wire push = i_req_valid & o_req_ready;
	wire [CNT_W-1:0] cnt_next = cnt_reg + CNT_W'(push) - CNT_W'(issue);
	wire issue_rd = issue & ~head.write;
	wire issue_wr = issue & head.write;
	wire ap = head.autopre & ~full;
	// Wait less one; read: precharge plus length, write: length-1 plus recovery plus precharge
	wire [WAIT_W-1:0] rd_wait = WAIT_W'(sdram_burst_pkg::PRECHARGE_CYC) + len_m;
	wire [WAIT_W-1:0] wr_wait = len_m + WAIT_W'(sdram_burst_pkg::WRITE_RECOVERY_CYC)
		+ WAIT_W'(sdram_burst_pkg::PRECHARGE_CYC) - WAIT_W'(1);
	wire [WAIT_W-1:0] rd_gap = WAIT_W'(cl3 ? sdram_burst_pkg::CL_3 : sdram_burst_pkg::CL_2)
		+ WAIT_W'(1);
	// Unmask exactly the first read word, at latency less two
	wire unmask = cl3 ? rd_sr_reg[0] : issue_rd;
	wire [ADDR_W-1:0] cmd_addr = ADDR_W'(head.col) | (ADDR_W'(ap) << sdram_burst_pkg::PSB_POS);

	// Buffer storage, no reset needed
	always_ff @(posedge i_sys_clk) begin
		if (push)
			buf_q[wr_ptr_reg] <= i_req;
	end

	// Buffer pointers; ready stalls the source when full
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
			o_req_ready <= 1'b0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + PTR_W'(1);
			if (issue)
				rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + PTR_W'(1);
			cnt_reg <= cnt_next;
			o_req_ready <= cnt_next != CNT_W'(DEPTH);
		end
	end

	// Spacing counters
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wait_reg <= '0;
			gap_reg <= '0;
		end else begin
			if (issue & ap)
				wait_reg <= head.write ? wr_wait : rd_wait;
			else if (wait_reg != '0)
				wait_reg <= wait_reg - WAIT_W'(1);
			// Keeps one released cycle before write data
			if (issue_rd)
				gap_reg <= rd_gap;
			else if (gap_reg != '0)
				gap_reg <= gap_reg - WAIT_W'(1);
		end
	end

	// Command pins; idle cycles deselect
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			bus.cs_n <= 1'b1;
			bus.ras_n <= 1'b1;
			bus.cas_n <= 1'b1;
			bus.we_n <= 1'b1;
			bus.ba <= '0;
			bus.addr <= '0;
			bus.dqm <= '1;
			bus.dq_c_out <= '0;
			bus.dq_c_oe <= '0;
		end else begin
			bus.cs_n <= ~issue;
			bus.ras_n <= 1'b1;
			bus.cas_n <= ~issue;
			bus.we_n <= ~issue_wr;
			if (issue) begin
				bus.ba <= head.bank;
				bus.addr <= cmd_addr;
			end
			// Mask high except own write word and wanted read word
			if (issue_wr)
				bus.dqm <= head.mask;
			else
				bus.dqm <= unmask ? '0 : '1;
			// Data only with the write command edge
			bus.dq_c_out <= head.data;
			bus.dq_c_oe <= issue_wr ? '1 : '0;
		end
	end

	// Read capture at the latency edge
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_sr_reg <= '0;
			o_rd_valid <= 1'b0;
			o_rd_data <= '0;
		end else begin
			rd_sr_reg <= {rd_sr_reg[2:0], issue_rd};
			o_rd_valid <= cl3 ? rd_sr_reg[3] : rd_sr_reg[2];
			o_rd_data <= bus.dq;
		end
	end
endmodule

// *** dv/sdram_link_sva.sv ***
// Checker for the pins between the SDRAM controller end and the memory end.
// Assumes one clock domain; the bench places it beside the joining link.
module sdram_link_sva (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// Command pins
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [sdram_burst_pkg::ADDR_W-1:0] addr,
	input wire logic [sdram_burst_pkg::MASK_W-1:0] dqm,
	// Lane enables of both ends
	input wire logic [sdram_burst_pkg::MASK_W-1:0] dq_c_oe,
	input wire logic [sdram_burst_pkg::MASK_W-1:0] dq_m_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// Column commands as the memory decodes them
	wire logic rd_cmd = !cs_n && ras_n && !cas_n && we_n;
	wire logic wr_cmd = !cs_n && ras_n && !cas_n && !we_n;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_b);
	// Latency covers both legal codes, so the bench may switch them
	a_read_latency: assert property (rd_cmd |-> ##[2:3] dq_m_oe == 2'h3)
		else $error("read word not driven two or three clocks after read");
	a_mask_gate: assert property ((dq_m_oe & $past(dqm, 2)) == 2'h0)
		else $error("lane driven though mask was high two clocks earlier");
	a_no_clash: assert property ((dq_m_oe & dq_c_oe) == 2'h0)
		else $error("both ends drive one lane");
	a_wr_gap: assert property (rd_cmd |=> !wr_cmd [*3])
		else $error("write too close behind read");
	// Quiet pins must leave the memory lanes released
	a_release_idle: assert property ((!rd_cmd) [*4] |=> dq_m_oe == 2'h0)
		else $error("memory lanes still driven after burst");
	a_wr_drive: assert property (wr_cmd |-> dq_c_oe == 2'h3)
		else $error("write data not driven with write command");
	a_wr_mask_after: assert property (wr_cmd ##1 cs_n |-> dqm == 2'h3)
		else $error("mask low after write word");
	a_cmd_kind: assert property (!cs_n |-> ras_n && !cas_n)
		else $error("command other than read or write");
	a_ap_gap: assert property (!cs_n && addr[sdram_burst_pkg::PSB_POS] |=> cs_n)
		else $error("command right after auto precharge");
	// Main traffic kinds
	c_read: cover property (rd_cmd);
	c_write: cover property (wr_cmd);
	c_back_to_back: cover property (rd_cmd ##1 rd_cmd);
endmodule

// *** dv/tb_top.sv ***
// Bench for the SDRAM controller end and memory end joined by one link.
// Assumes design/ package and interface; a second link drives a memory directly.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Pin codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] C_NOP = 4'h7;
	localparam logic [3:0] C_RD = 4'h5;
	localparam logic [3:0] C_WR = 4'h4;
	localparam logic [3:0] C_PRE = 4'h2;
	localparam logic [3:0] C_OFF = 4'hd;
	// One request and the read word it should give
	typedef struct packed {
		logic w;
		logic a;
		logic [1:0] b;
		logic [9:0] c;
		logic [15:0] d;
		logic [1:0] m;
		logic [15:0] e;
	} row_s;
	localparam row_s ROWS [8] = '{
		'{1'b1, 1'b0, 2'h0, 10'h005, 16'h1234, 2'h0, 16'h0000},
		'{1'b0, 1'b0, 2'h0, 10'h005, 16'h0000, 2'h0, 16'h1234},
		'{1'b1, 1'b0, 2'h0, 10'h005, 16'hffff, 2'h1, 16'h0000},
		'{1'b0, 1'b0, 2'h0, 10'h005, 16'h0000, 2'h0, 16'hff34},
		'{1'b1, 1'b0, 2'h3, 10'h3ff, 16'ha5c3, 2'h0, 16'h0000},
		'{1'b0, 1'b0, 2'h3, 10'h3ff, 16'h0000, 2'h0, 16'ha5c3},
		'{1'b1, 1'b1, 2'h2, 10'h000, 16'h5a5a, 2'h0, 16'h0000},
		'{1'b0, 1'b0, 2'h2, 10'h000, 16'h0000, 2'h0, 16'h5a5a}
	};
	logic i_sys_clk;
	logic i_rst_b;
	logic [2:0] bl_code;
	logic bt;
	logic [2:0] cl_code;
	logic [3:0] banks;
	logic req_valid;
	sdram_burst_pkg::req_s req;
	logic req_ready, rd_valid, busy, busy2, ap_req, ap_req2;
	logic [15:0] rd_data;
	logic [1:0] ap_bank, ap_bank2;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	sdram_link_if link ();
	sdram_link_if link2 ();
	sdram_burst_ctrl sdram_burst_ctrl_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .bus(link),
		.i_burst_len_code(bl_code), .i_cas_lat_code(cl_code), .i_bank_ready(banks),
		.i_req_valid(req_valid), .i_req(req), .o_req_ready(req_ready),
		.o_rd_valid(rd_valid), .o_rd_data(rd_data));
	sdram_burst_mem sdram_burst_mem_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .bus(link),
		.i_burst_len_code(bl_code), .i_burst_type(bt), .i_cas_lat_code(cl_code),
		.i_bank_active(banks), .o_busy(busy), .o_ap_req(ap_req), .o_ap_bank(ap_bank));
	// Second memory, its pins driven by the bench
	sdram_burst_mem sdram_burst_mem_i2 (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .bus(link2),
		.i_burst_len_code(bl_code), .i_burst_type(bt), .i_cas_lat_code(cl_code),
		.i_bank_active(banks), .o_busy(busy2), .o_ap_req(ap_req2), .o_ap_bank(ap_bank2));
	sdram_link_sva sdram_link_sva_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
		.cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
		.addr(link.addr), .dqm(link.dqm), .dq_c_oe(link.dq_c_oe), .dq_m_oe(link.dq_m_oe));
	// Clock of 40 ns
	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	// Hang guard, well above the fewer than two hundred cycles the tests take
	always @(posedge i_sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("counts: %0d compares, %0d mismatches", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// Offer a request; returns at the falling edge before the edge that takes it
	task automatic push(input sdram_burst_pkg::req_s r);
		int n;
		n = 0;
		@(negedge i_sys_clk);
		req_valid = 1'b1;
		req = r;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge i_sys_clk);
			n++;
		end
		if (n == 50)
			chk("request ready", 16'h0001, 16'h0000);
	endtask
	task automatic idle();
		@(negedge i_sys_clk);
		req_valid = 1'b0;
	endtask
	// Wait a bounded time for a read answer
	task automatic get(input logic [15:0] exp);
		int n;
		n = 0;
		while (rd_valid !== 1'b1 && n < 40) begin
			@(negedge i_sys_clk);
			n++;
		end
		chk("read answer", exp, n < 40 ? rd_data : ~exp);
		@(negedge i_sys_clk);
	endtask
	// One cycle of pins on the bench link
	task automatic drive(input logic [3:0] c, input logic [12:0] a, input logic [1:0] m,
		input logic [1:0] oe, input logic [15:0] d);
		@(negedge i_sys_clk);
		{link2.cs_n, link2.ras_n, link2.cas_n, link2.we_n} = c;
		link2.addr = a;
		link2.dqm = m;
		link2.dq_c_oe = oe;
		link2.dq_c_out = d;
	endtask
	// Burst read on the bench link; columns 0..3 hold 16'h1000 + ((col - 2) mod 4)
	task automatic rd_burst(input logic [9:0] s, input logic [1:0] m, input int n, input int cl);
		logic [9:0] col;
		logic [15:0] exp;
		drive(C_RD, {3'h0, s}, m, 2'h0, 16'h0000);
		for (int j = 1; j < cl + n; j++) begin
			drive(C_NOP, 13'h0000, m, 2'h0, 16'h0000);
			if (j >= cl) begin
				col = bt ? s ^ 10'(j - cl) : {s[9:2], 2'(s[1:0] + 2'(j - cl))};
				// Cut to two bits first, so the offset wraps within the block
				exp = 16'h1000 + 16'(2'(col[1:0] - 2'h2));
				chk("burst word", exp & {{8{~m[1]}}, {8{~m[0]}}}, link2.dq);
			end
		end
	endtask
	// Count auto precharge pulses for bank 1, then close the burst
	task automatic ap_check(input logic [3:0] c, input int exp);
		int n;
		n = 0;
		drive(c, 13'h0400, 2'h3, 2'h0, 16'h0000);
		repeat (8) begin
			drive(C_NOP, 13'h0000, 2'h3, 2'h0, 16'h0000);
			n += int'(ap_req2 === 1'b1 && ap_bank2 === 2'h1);
		end
		// Mask high since the burst, and well past recovery
		drive(C_PRE, 13'h0000, 2'h3, 2'h0, 16'h0000);
		chk("auto precharge pulses", 16'(exp), 16'(n));
	endtask
	initial begin
		i_rst_b = 1'b0;
		bl_code = sdram_burst_pkg::BL_CODE_1;
		bt = 1'b0;
		cl_code = sdram_burst_pkg::CL_CODE_2;
		banks = 4'hf;
		req_valid = 1'b0;
		req = '0;
		link2.ba = 2'h1;
		{link2.cs_n, link2.ras_n, link2.cas_n, link2.we_n} = 4'hf;
		link2.addr = 13'h0000;
		link2.dqm = 2'h3;
		link2.dq_c_oe = 2'h0;
		link2.dq_c_out = 16'h0000;
		repeat (20) @(negedge i_sys_clk);
		chk("pins in reset", 16'h000e, {12'h000, link.cs_n, link.dqm, req_ready});
		i_rst_b = 1'b1;
		repeat (2) @(negedge i_sys_clk);
		chk("ready after reset", 16'h0001, {15'h0000, req_ready});
		$display("test reset done");
		// Table pass once per CAS latency code
		for (int p = 0; p < 2; p++) begin
			cl_code = p ? sdram_burst_pkg::CL_CODE_3 : sdram_burst_pkg::CL_CODE_2;
			foreach (ROWS[i]) begin
				push({ROWS[i].w, ROWS[i].a, ROWS[i].b, ROWS[i].c, ROWS[i].d, ROWS[i].m});
				idle();
				if (!ROWS[i].w)
					get(ROWS[i].e);
			end
		end
		$display("test table done");
		// Stalled banks: fill the buffer, hold a refused third request, then drain
		banks = 4'h0;
		push({1'b0, 1'b0, 2'h0, 10'h005, 16'h0000, 2'h0});
		push({1'b0, 1'b0, 2'h3, 10'h3ff, 16'h0000, 2'h0});
		@(negedge i_sys_clk);
		req = {1'b0, 1'b0, 2'h0, 10'h005, 16'h0000, 2'h0};
		chk("ready when full", 16'h0000, {15'h0000, req_ready});
		banks = 4'hf;
		push(req);
		idle();
		get(16'hff34);
		get(16'ha5c3);
		get(16'hff34);
		$display("test buffer done");
		// Burst of four on the bench link, then both orders
		bl_code = sdram_burst_pkg::BL_CODE_4;
		cl_code = sdram_burst_pkg::CL_CODE_2;
		drive(C_WR, 13'h0002, 2'h0, 2'h3, 16'h1000);
		for (int i = 1; i < 4; i++)
			drive(C_NOP, 13'h0000, 2'h0, 2'h3, 16'h1000 + 16'(i));
		drive(C_NOP, 13'h0000, 2'h3, 2'h0, 16'h0000);
		rd_burst(10'h001, 2'h0, 4, 2);
		// Let the read pipe drain before the latency changes
		drive(C_NOP, 13'h0000, 2'h3, 2'h0, 16'h0000);
		cl_code = sdram_burst_pkg::CL_CODE_3;
		bt = 1'b1;
		rd_burst(10'h001, 2'h2, 4, 3);
		bt = 1'b0;
		// Deselected read must stay silent
		drive(C_OFF, 13'h0001, 2'h0, 2'h0, 16'h0000);
		repeat (4) begin
			drive(C_NOP, 13'h0000, 2'h0, 2'h0, 16'h0000);
			chk("lanes while deselected", 16'h0000, {14'h0000, link2.dq_m_oe});
		end
		$display("test bursts done");
		// Full page write across the page end, cut by a read, then by a precharge
		bl_code = sdram_burst_pkg::BL_CODE_FULL;
		cl_code = sdram_burst_pkg::CL_CODE_2;
		drive(C_WR, 13'h03ff, 2'h0, 2'h3, 16'h2000);
		drive(C_NOP, 13'h0000, 2'h0, 2'h3, 16'h2001);
		drive(C_RD, 13'h03ff, 2'h0, 2'h0, 16'h0000);
		for (int j = 1; j < 5; j++) begin
			drive(C_NOP, 13'h0000, 2'h0, 2'h0, 16'h0000);
			if (j >= 2)
				chk("page word", j < 4 ? 16'h2000 + 16'(j - 2) : 16'h1003, link2.dq);
		end
		chk("busy in page burst", 16'h0001, {15'h0000, busy2});
		// Precharge of all banks ends the running page read
		drive(C_PRE, 13'h0400, 2'h3, 2'h0, 16'h0000);
		drive(C_NOP, 13'h0000, 2'h3, 2'h0, 16'h0000);
		chk("busy after precharge", 16'h0000, {15'h0000, busy2});
		$display("test full page done");
		// Auto precharge at length two, ignored at full page
		bl_code = sdram_burst_pkg::BL_CODE_2;
		ap_check(C_RD, 1);
		ap_check(C_WR, 1);
		bl_code = sdram_burst_pkg::BL_CODE_FULL;
		ap_check(C_RD, 0);
		$display("test auto precharge done");
		wrap_up();
	end
endmodule
